// ### sdrt_clkdiv.sv
`timescale 1ns/1ns
module sdrt_clkdiv
  import sdrt_pkg::*;
#(
  parameter int unsigned SYS_DIV = SDRT_SYS_DIV,
  parameter int unsigned EXT_DIV = SDRT_EXT_DIV
)(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ext_clk,
  output logic      tick_sys,
  output logic      tick_ext
);

  if (SYS_DIV < 2 || SYS_DIV > 16 || EXT_DIV < 2 || EXT_DIV > 16)
  begin : g_bad_div
    $error("sdrt_clkdiv: dividers must lie in 2..16");
  end

  typedef struct packed {
    logic [3:0] sys_cnt;
    logic [3:0] ext_cnt;
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic       tick_sys;
    logic       tick_ext;
  } sdrt_div_state_type;

  sdrt_div_state_type s_r;
  sdrt_div_state_type s_nxt;

  always_comb
  begin
    s_nxt          = s_r;
    // sync1 feeds only sync2; edges are judged on the later stages
    s_nxt.sync1    = ext_clk;
    s_nxt.sync2    = s_r.sync1;
    s_nxt.sync3    = s_r.sync2;
    s_nxt.tick_sys = 1'b0;
    s_nxt.tick_ext = 1'b0;
    if (s_r.sys_cnt == 4'(SYS_DIV - 1))
    begin
      s_nxt.sys_cnt  = 4'h0;
      s_nxt.tick_sys = 1'b1;
    end
    else
    begin
      s_nxt.sys_cnt = s_r.sys_cnt + 4'h1;
    end
    if (s_r.sync2 && !s_r.sync3)
    begin
      if (s_r.ext_cnt == 4'(EXT_DIV - 1))
      begin
        s_nxt.ext_cnt  = 4'h0;
        s_nxt.tick_ext = 1'b1;
      end
      else
      begin
        s_nxt.ext_cnt = s_r.ext_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_sys = s_r.tick_sys;
  assign tick_ext = s_r.tick_ext;

endmodule // sdrt_clkdiv

// ### sdrt_half.sv
`timescale 1ns/1ns
module sdrt_half
  import sdrt_pkg::*;
#(
  parameter int unsigned W = SDRT_CNT_W
)(
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] reload,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] count,
  output logic              ovf
);

  if (W < 2 || W > 16)
  begin : g_bad_w
    $error("sdrt_half: width must lie in 2..16");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } sdrt_half_state_type;

  sdrt_half_state_type s_r;
  sdrt_half_state_type s_nxt;

  // a software write to the count takes precedence over a tick
  assign ovf = tick && run && (&s_r.cnt) && !load;

  always_comb
  begin
    s_nxt = s_r;
    if (load)
      s_nxt.cnt = load_val;
    else if (ovf)
      s_nxt.cnt = reload;
    else if (tick && run)
      s_nxt.cnt = s_r.cnt + W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign count = s_r.cnt;

endmodule // sdrt_half

// ### sdrt_pkg.sv
package sdrt_pkg;

  // register map
  localparam int unsigned     SDRT_ADDR_W        = 4;
  localparam logic [3:0]      SDRT_ADDR_CTRL     = 4'h0;
  localparam logic [3:0]      SDRT_ADDR_CLKCTRL  = 4'h1;
  localparam logic [3:0]      SDRT_ADDR_LOW_CNT  = 4'h2;
  localparam logic [3:0]      SDRT_ADDR_HIGH_CNT = 4'h3;
  localparam logic [3:0]      SDRT_ADDR_LOW_RLD  = 4'h4;
  localparam logic [3:0]      SDRT_ADDR_HIGH_RLD = 4'h5;

  // timer_control_register fields
  localparam int unsigned     SDRT_CTRL_HOF      = 7;
  localparam int unsigned     SDRT_CTRL_LOF      = 6;
  localparam int unsigned     SDRT_CTRL_LIE      = 5;
  localparam int unsigned     SDRT_CTRL_SPLIT    = 4;
  localparam int unsigned     SDRT_CTRL_CAPT     = 3;
  localparam int unsigned     SDRT_CTRL_RUN      = 2;
  localparam int unsigned     SDRT_CTRL_IE       = 1;
  localparam int unsigned     SDRT_CTRL_XCLK     = 0;

  // clock_control_register fields
  localparam int unsigned     SDRT_CLK_HFAST     = 1;
  localparam int unsigned     SDRT_CLK_LFAST     = 0;

  // reset values
  localparam logic [7:0]      SDRT_CTRL_RST      = 8'h00;
  localparam logic [7:0]      SDRT_CLK_RST       = 8'h00;
  localparam logic [7:0]      SDRT_CNT_RST       = 8'h00;
  localparam logic [7:0]      SDRT_RLD_RST       = 8'h00;

  // timing
  localparam int unsigned     SDRT_SYS_DIV       = 12;
  localparam int unsigned     SDRT_EXT_DIV       = 8;
  localparam int unsigned     SDRT_CNT_W         = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sdrt_bus_req_type;

endpackage

// ### sdrt_timer.sv
//Contract
// R1 - With split selected and capture off, the timer runs as two separate 8-bit counters.
// R2 - In split mode each counter reloads from its own reload register.
// R3 - The run-control bit starts and stops only the high counter.
// R4 - The low counter counts continuously in split mode, ignoring run-control.
// R5 - The high counter ticks at core rate if fast, else core/12 or external/8 by select.
// R6 - The low counter uses the same choice with its own fast bit and the shared select.
// R7 - The high overflow flag sets when the high counter wraps from 0xff to 0x00.
// R8 - The low overflow flag sets when the low counter wraps from 0xff to 0x00.
// R9 - With the timer interrupt enabled, every high overflow raises the request.
// R10 - With the interrupt and the low-overflow enable set, either overflow raises it.
// R11 - Overflow flags are never cleared by hardware, only by a software write.
// R12 - On the overflow edge the counter loads its reload value.
// R13 - The divided rates are count enables on core_clk, the external clock synchronised first.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module sdrt_timer
  import sdrt_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             ext_clk,
  input  wire sdrt_bus_req_type bus_req,
  output logic      [7:0]       rd_data,
  output logic                  irq
);

  typedef struct packed {
    logic       hof;
    logic       lof;
    logic       lie;
    logic       split;
    logic       capt;
    logic       run;
    logic       ie;
    logic       xclk;
    logic       hfast;
    logic       lfast;
    logic [7:0] low_rld;
    logic [7:0] high_rld;
    logic       irq;
    logic [7:0] rd_data;
  } sdrt_state_type;

  sdrt_state_type s_r;
  sdrt_state_type s_nxt;

  logic       tick_sys;
  logic       tick_ext;
  logic       split_on;
  logic       tick_h;
  logic       tick_l;
  logic       load_h;
  logic       load_l;
  logic       ovf_h;
  logic       ovf_l;
  logic [7:0] cnt_h;
  logic [7:0] cnt_l;
  logic       wr_ctrl;
  logic [7:0] ctrl_rd;
  logic [7:0] clk_rd;

  sdrt_clkdiv #(
    .SYS_DIV (SDRT_SYS_DIV),
    .EXT_DIV (SDRT_EXT_DIV)
  ) u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .ext_clk  (ext_clk),
    .tick_sys (tick_sys),
    .tick_ext (tick_ext)
  );

  assign split_on = s_r.split && !s_r.capt; // R1

  // three-way rate choice per half
  assign tick_h = s_r.hfast ? 1'b1 : (s_r.xclk ? tick_ext : tick_sys); // R5 R13
  assign tick_l = s_r.lfast ? 1'b1 : (s_r.xclk ? tick_ext : tick_sys); // R6 R13

  assign load_h = bus_req.wr && (bus_req.addr == SDRT_ADDR_HIGH_CNT);
  assign load_l = bus_req.wr && (bus_req.addr == SDRT_ADDR_LOW_CNT);
  assign wr_ctrl = bus_req.wr && (bus_req.addr == SDRT_ADDR_CTRL);

  sdrt_half #(
    .W (SDRT_CNT_W)
  ) u_high (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tick_h),
    .run      (split_on && s_r.run), // R3
    .reload   (s_r.high_rld), // R2 R12
    .load     (load_h),
    .load_val (bus_req.wdata),
    .count    (cnt_h),
    .ovf      (ovf_h)
  );

  sdrt_half #(
    .W (SDRT_CNT_W)
  ) u_low (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tick_l),
    .run      (split_on), // R4
    .reload   (s_r.low_rld), // R2 R12
    .load     (load_l),
    .load_val (bus_req.wdata),
    .count    (cnt_l),
    .ovf      (ovf_l)
  );

  always_comb
  begin
    ctrl_rd                   = 8'h00;
    ctrl_rd[SDRT_CTRL_HOF]    = s_r.hof;
    ctrl_rd[SDRT_CTRL_LOF]    = s_r.lof;
    ctrl_rd[SDRT_CTRL_LIE]    = s_r.lie;
    ctrl_rd[SDRT_CTRL_SPLIT]  = s_r.split;
    ctrl_rd[SDRT_CTRL_CAPT]   = s_r.capt;
    ctrl_rd[SDRT_CTRL_RUN]    = s_r.run;
    ctrl_rd[SDRT_CTRL_IE]     = s_r.ie;
    ctrl_rd[SDRT_CTRL_XCLK]   = s_r.xclk;
    clk_rd                    = 8'h00;
    clk_rd[SDRT_CLK_HFAST]    = s_r.hfast;
    clk_rd[SDRT_CLK_LFAST]    = s_r.lfast;
  end

  always_comb
  begin
    s_nxt = s_r;
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        SDRT_ADDR_CTRL:
        begin
          s_nxt.hof   = bus_req.wdata[SDRT_CTRL_HOF];
          s_nxt.lof   = bus_req.wdata[SDRT_CTRL_LOF];
          s_nxt.lie   = bus_req.wdata[SDRT_CTRL_LIE];
          s_nxt.split = bus_req.wdata[SDRT_CTRL_SPLIT];
          s_nxt.capt  = bus_req.wdata[SDRT_CTRL_CAPT];
          s_nxt.run   = bus_req.wdata[SDRT_CTRL_RUN];
          s_nxt.ie    = bus_req.wdata[SDRT_CTRL_IE];
          s_nxt.xclk  = bus_req.wdata[SDRT_CTRL_XCLK];
        end
        SDRT_ADDR_CLKCTRL:
        begin
          s_nxt.hfast = bus_req.wdata[SDRT_CLK_HFAST];
          s_nxt.lfast = bus_req.wdata[SDRT_CLK_LFAST];
        end
        SDRT_ADDR_LOW_RLD:  s_nxt.low_rld  = bus_req.wdata;
        SDRT_ADDR_HIGH_RLD: s_nxt.high_rld = bus_req.wdata;
        default:            ;
      endcase
    end
    // an overflow in the cycle of a clearing write still leaves the flag set
    if (ovf_h)
      s_nxt.hof = 1'b1; // R7 R11
    if (ovf_l)
      s_nxt.lof = 1'b1; // R8 R11
    // request follows the flags in the same edge that sets them
    s_nxt.irq = s_nxt.ie && (s_nxt.hof || (s_nxt.lie && s_nxt.lof)); // R9 R10
    s_nxt.rd_data = 8'h00;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        SDRT_ADDR_CTRL:     s_nxt.rd_data = ctrl_rd;
        SDRT_ADDR_CLKCTRL:  s_nxt.rd_data = clk_rd;
        SDRT_ADDR_LOW_CNT:  s_nxt.rd_data = cnt_l;
        SDRT_ADDR_HIGH_CNT: s_nxt.rd_data = cnt_h;
        SDRT_ADDR_LOW_RLD:  s_nxt.rd_data = s_r.low_rld;
        SDRT_ADDR_HIGH_RLD: s_nxt.rd_data = s_r.high_rld;
        default:            s_nxt.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_r          <= '0;
      s_r.low_rld  <= SDRT_RLD_RST;
      s_r.high_rld <= SDRT_RLD_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
  assign irq     = s_r.irq;

  // checks

  no_split_hold_a: assert property (@(posedge core_clk) disable iff (srst) // R1
    !split_on && !load_h && !load_l |=> $stable(cnt_h) && $stable(cnt_l))
    else $error("counter moved outside split mode");

  high_reload_a: assert property (@(posedge core_clk) disable iff (srst) // R2
    ovf_h |=> cnt_h == $past(s_r.high_rld))
    else $error("high counter did not reload");

  low_reload_a: assert property (@(posedge core_clk) disable iff (srst) // R12
    ovf_l |=> cnt_l == $past(s_r.low_rld))
    else $error("low counter did not reload");

  high_stop_a: assert property (@(posedge core_clk) disable iff (srst) // R3
    split_on && !s_r.run && !load_h |=> $stable(cnt_h))
    else $error("high counter ran while stopped");

  // a reload value of 0xff makes a wrap look like a standstill
  low_free_a: assert property (@(posedge core_clk) disable iff (srst) // R4
    split_on && s_r.lfast && !load_l
    |=> cnt_l != $past(cnt_l) || $past(s_r.low_rld) == 8'hff)
    else $error("low counter did not advance");

  high_fast_a: assert property (@(posedge core_clk) disable iff (srst) // R5
    split_on && s_r.run && s_r.hfast && !load_h
    |=> cnt_h != $past(cnt_h) || $past(s_r.high_rld) == 8'hff)
    else $error("high counter ignored fast clock");

  sys_div_a: assert property (@(posedge core_clk) disable iff (srst) // R13
    tick_sys |=> !tick_sys [*8] ##1 !tick_sys [*3] ##1 tick_sys)
    else $error("core divider period wrong");

  low_slow_a: assert property (@(posedge core_clk) disable iff (srst) // R6
    split_on && !s_r.lfast && !s_r.xclk && !tick_sys && !load_l |=> $stable(cnt_l))
    else $error("low counter ticked without enable");

  high_flag_a: assert property (@(posedge core_clk) disable iff (srst) // R7
    ovf_h |=> s_r.hof)
    else $error("high flag not set on overflow");

  low_flag_a: assert property (@(posedge core_clk) disable iff (srst) // R8
    ovf_l |=> s_r.lof)
    else $error("low flag not set on overflow");

  flag_sticky_a: assert property (@(posedge core_clk) disable iff (srst) // R11
    (s_r.hof || s_r.lof) && !wr_ctrl |=> s_r.hof >= $past(s_r.hof) && s_r.lof >= $past(s_r.lof))
    else $error("flag cleared by hardware");

  irq_high_a: assert property (@(posedge core_clk) disable iff (srst) // R9
    ovf_h && s_r.ie && !wr_ctrl |=> irq)
    else $error("no request on high overflow");

  irq_low_a: assert property (@(posedge core_clk) disable iff (srst) // R10
    ovf_l && s_r.ie && s_r.lie && !wr_ctrl |=> irq)
    else $error("no request on low overflow");

  irq_mask_a: assert property (@(posedge core_clk) disable iff (srst) // R10
    !s_r.ie && !wr_ctrl |=> !irq)
    else $error("request while disabled");

  // counting steps
  high_count_a: assert property (@(posedge core_clk) disable iff (srst) // R3
    split_on && s_r.run && tick_h && !load_h && !ovf_h |=> cnt_h == $past(cnt_h) + 8'h01)
    else $error("high counter missed a step");

  low_count_a: assert property (@(posedge core_clk) disable iff (srst) // R4
    split_on && tick_l && !load_l && !ovf_l |=> cnt_l == $past(cnt_l) + 8'h01)
    else $error("low counter missed a step");

  high_wrap_a: assert property (@(posedge core_clk) disable iff (srst) // R7
    split_on && s_r.run && tick_h && cnt_h == 8'hff && !load_h |-> ovf_h)
    else $error("high wrap not seen");

  low_wrap_a: assert property (@(posedge core_clk) disable iff (srst) // R8
    split_on && tick_l && cnt_l == 8'hff && !load_l |-> ovf_l)
    else $error("low wrap not seen");

  high_slow_a: assert property (@(posedge core_clk) disable iff (srst) // R5
    split_on && !s_r.hfast && !s_r.xclk && !tick_sys && !load_h |=> $stable(cnt_h))
    else $error("high counter ticked without enable");

  high_ext_a: assert property (@(posedge core_clk) disable iff (srst) // R5
    split_on && !s_r.hfast && s_r.xclk && !tick_ext && !load_h |=> $stable(cnt_h))
    else $error("high counter ticked without external enable");

  low_ext_a: assert property (@(posedge core_clk) disable iff (srst) // R6
    split_on && !s_r.lfast && s_r.xclk && !tick_ext && !load_l |=> $stable(cnt_l))
    else $error("low counter ticked without external enable");

  // eight synchronised rising edges take at least sixteen cycles
  ext_div_a: assert property (@(posedge core_clk) disable iff (srst) // R13
    tick_ext |=> !tick_ext [*8] ##1 !tick_ext [*7])
    else $error("external divider too fast");

  high_load_a: assert property (@(posedge core_clk) disable iff (srst)
    load_h |=> cnt_h == $past(bus_req.wdata))
    else $error("high counter write lost");

  low_load_a: assert property (@(posedge core_clk) disable iff (srst)
    load_l |=> cnt_l == $past(bus_req.wdata))
    else $error("low counter write lost");

  // flags and request
  high_keep_a: assert property (@(posedge core_clk) disable iff (srst) // R7
    !ovf_h && !wr_ctrl |=> s_r.hof == $past(s_r.hof))
    else $error("high flag changed on its own");

  low_keep_a: assert property (@(posedge core_clk) disable iff (srst) // R8
    !ovf_l && !wr_ctrl |=> s_r.lof == $past(s_r.lof))
    else $error("low flag changed on its own");

  high_clear_a: assert property (@(posedge core_clk) disable iff (srst) // R11
    wr_ctrl && !bus_req.wdata[SDRT_CTRL_HOF] && !ovf_h |=> !s_r.hof)
    else $error("high flag not cleared by write");

  low_clear_a: assert property (@(posedge core_clk) disable iff (srst) // R11
    wr_ctrl && !bus_req.wdata[SDRT_CTRL_LOF] && !ovf_l |=> !s_r.lof)
    else $error("low flag not cleared by write");

  irq_hold_a: assert property (@(posedge core_clk) disable iff (srst) // R9
    irq && !wr_ctrl |=> irq)
    else $error("request dropped while flags stand");

  irq_low_mask_a: assert property (@(posedge core_clk) disable iff (srst) // R10
    s_r.ie && !s_r.lie && !s_r.hof && !wr_ctrl && !ovf_h |=> !irq)
    else $error("low overflow raised request while masked");

  // read port
  rd_idle_a: assert property (@(posedge core_clk) disable iff (srst)
    !bus_req.rd |=> rd_data == 8'h00)
    else $error("read data stood too long");

  rd_unmapped_a: assert property (@(posedge core_clk) disable iff (srst)
    bus_req.rd && bus_req.addr > SDRT_ADDR_HIGH_RLD |=> rd_data == 8'h00)
    else $error("unmapped read returned data");

endmodule // sdrt_timer

// ### test_sdrt_timer.sv
`timescale 1ns/1ns
module test_sdrt_timer
  import sdrt_pkg::*;
;
  // counting window; chosen so every tick rate fits a whole number of times
  localparam int         WIN = 480;
  localparam logic [7:0] FST = 8'(WIN);
  localparam logic [7:0] S12 = 8'(WIN / SDRT_SYS_DIV);
  // ext_clk has a period of 6 core cycles
  localparam logic [7:0] EXT = 8'(WIN / (6 * SDRT_EXT_DIV));
  localparam logic [7:0] ROW_CTRL [8] = '{8'h14, 8'h14, 8'h15, 8'h14, 8'h15, 8'h10, 8'h1c, 8'h04};
  localparam logic [7:0] ROW_CLK  [8] = '{8'h03, 8'h02, 8'h01, 8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
  localparam logic [7:0] EXP_HI   [8] = '{FST, FST, EXT, S12, EXT, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] EXP_LO   [8] = '{FST, S12, FST, S12, EXT, FST, 8'h00, 8'h00};

  logic             core_clk;
  logic             srst;
  logic             ext_clk;
  sdrt_bus_req_type bus_req;
  logic [7:0]       rd_data;
  logic             irq;
  int               error_cnt;
  int               samples_checked;
  logic [7:0]       d0;
  logic [7:0]       lo0;
  logic [7:0]       lo1;
  logic [7:0]       hi0;
  logic [7:0]       hi1;

  sdrt_timer dut_u (
    .core_clk (core_clk),
    .srst     (srst),
    .ext_clk  (ext_clk),
    .bus_req  (bus_req),
    .rd_data  (rd_data),
    .irq      (irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // offset by 3 ns so its edges never meet core_clk edges
  initial
  begin
    ext_clk = 1'b0;
    #3;
    forever #30 ext_clk = ~ext_clk;
  end

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t irq %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // strobes rise and fall on clock edges; one idle cycle between calls
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    @(posedge core_clk);
    bus_req.wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge core_clk);
    bus_req.rd   <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic wait_irq(input int limit);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < limit)
    begin
      tick(1);
      n++;
    end
    chk1(irq, 1'b1);
    if (irq !== 1'b1)
      end_sim();
  endtask

  initial
  begin
    error_cnt       = 0;
    samples_checked = 0;
    srst            = 1'b1;
    bus_req         = '0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);

    // reset values, unmapped address, read data standing one cycle only
    wr_reg(4'hf, 8'hff);
    for (int a = 0; a < 6; a++)
    begin
      rd_reg(4'(a), d0);
      chk8(d0, 8'h00);
    end
    rd_reg(4'hf, d0);
    chk8(d0, 8'h00);
    tick(1);
    chk8(rd_data, 8'h00);
    chk1(irq, 1'b0);
    $display("test reset done");

    // counters loaded while split is off; with split on and run off only the low counter then moves
    wr_reg(SDRT_ADDR_CTRL, 8'h00);
    wr_reg(SDRT_ADDR_CLKCTRL, 8'h03);
    wr_reg(SDRT_ADDR_LOW_RLD, 8'h80);
    wr_reg(SDRT_ADDR_HIGH_RLD, 8'h40);
    wr_reg(SDRT_ADDR_LOW_CNT, 8'hfe);
    wr_reg(SDRT_ADDR_HIGH_CNT, 8'hfe);
    wr_reg(SDRT_ADDR_CTRL, 8'h12);
    tick(10);
    rd_reg(SDRT_ADDR_HIGH_CNT, d0);
    chk8(d0, 8'hfe);
    rd_reg(SDRT_ADDR_CTRL, d0);
    chk8(d0, 8'h52);
    chk1(irq, 1'b0);
    rd_reg(SDRT_ADDR_LOW_CNT, d0);
    chk8(d0 & 8'hf0, 8'h80);
    wr_reg(SDRT_ADDR_CTRL, 8'h16);
    tick(5);
    rd_reg(SDRT_ADDR_CTRL, d0);
    chk8(d0, 8'h96);
    chk1(irq, 1'b1);
    rd_reg(SDRT_ADDR_HIGH_CNT, d0);
    chk8(d0 & 8'hf0, 8'h40);
    tick(60);
    rd_reg(SDRT_ADDR_CTRL, d0);
    chk8(d0, 8'h96);
    chk1(irq, 1'b1);
    wr_reg(SDRT_ADDR_CTRL, 8'h12);
    tick(2);
    chk1(irq, 1'b0);
    wr_reg(SDRT_ADDR_CTRL, 8'h32);
    wait_irq(300);
    rd_reg(SDRT_ADDR_CTRL, d0);
    chk8(d0, 8'h72);
    tick(1);
    chk8(rd_data, 8'h00);
    $display("test flags done");

    // tick rates per clock choice, run control, capture and split off
    wr_reg(SDRT_ADDR_CTRL, 8'h00);
    wr_reg(SDRT_ADDR_LOW_RLD, 8'h00);
    wr_reg(SDRT_ADDR_HIGH_RLD, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(SDRT_ADDR_CLKCTRL, ROW_CLK[i]);
      wr_reg(SDRT_ADDR_CTRL, ROW_CTRL[i]);
      tick(8);
      rd_reg(SDRT_ADDR_LOW_CNT, lo0);
      rd_reg(SDRT_ADDR_HIGH_CNT, hi0);
      // each access spans two cycles, so both reads stay WIN cycles apart
      tick(WIN - 4);
      rd_reg(SDRT_ADDR_LOW_CNT, lo1);
      rd_reg(SDRT_ADDR_HIGH_CNT, hi1);
      chk8(lo1 - lo0, EXP_LO[i]);
      chk8(hi1 - hi0, EXP_HI[i]);
    end
    $display("test rates done");

    // reset in mid-run clears flags, enables, reloads and the request
    wr_reg(SDRT_ADDR_LOW_RLD, 8'h5a);
    wr_reg(SDRT_ADDR_CTRL, 8'hd2);
    tick(2);
    chk1(irq, 1'b1);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk1(irq, 1'b0);
    rd_reg(SDRT_ADDR_CTRL, d0);
    chk8(d0, 8'h00);
    rd_reg(SDRT_ADDR_LOW_RLD, d0);
    chk8(d0, 8'h00);
    $display("test reset again done");
    end_sim();
  end

endmodule // test_sdrt_timer
